// file: design/drr_cfg.svh
// Constants of the request router: register map, field layout, source codes.
// Assumes inclusion by bare name from the router package and modules.
// Function
// - Eight extra sources are always asserted and ignore peripheral flow control.
// - Enabled always-on source re-activates its channel continuously, from the first tick on when gated.
// - Codes 0x23 to 0x2A are always-on; bytes 0xE3 to 0xEA add enable and gate.
// - Reset clears every source field so no request reaches any channel.
// - Software blocks any peripheral request through channel configuration alone.
// - Channels 8 to 15 route directly; the gate bit there has no effect.
// - Byte 0xC5 on channel 3 routes source 5 through the periodic gate.
// - Byte 0x85 on channel 3 routes source 5 straight through.
// - Channel n of 0 to 7 is gated by timer n+1; channel 3 uses timer 4.
// - Byte 0x89 on channel 0 routes source 0x09 directly.
// - Byte 0x8D on channel 9 at offset 0x0009 routes source 0x0D enabled.
// - Config byte: enable bit 7, gate select bit 6, source bits 5 to 0.
// - Periodic mode blocks a request until a tick; negation of the request re-arms.
// - A tick with no peripheral request sends nothing for that period.
`ifndef DRR_CFG_SVH
`define DRR_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define DRR_NUM_CH 16
`define DRR_NUM_GATED 8
`define DRR_NUM_PERIPH 35
`define DRR_ADDR_W 4
`define DRR_DATA_W 8
`define DRR_SRC_W 6

// ----------------------------------------
// Register map and field layout
// ----------------------------------------
`define DRR_OFS_CFG_CH3 4'h3
`define DRR_OFS_CFG_CH9 4'h9
`define DRR_BIT_ENABLE 7
`define DRR_BIT_GATE 6
`define DRR_SRC_HI 5
`define DRR_SRC_LO 0
`define DRR_CFG_RESET 8'h00

// ----------------------------------------
// Source codes
// ----------------------------------------
`define DRR_SRC_NONE 6'h00
`define DRR_SRC_ALWAYS_LO 6'h23
`define DRR_SRC_ALWAYS_HI 6'h2A
`define DRR_SRC_PERIPH_HI 6'h22

`endif

// file: design/drr_pkg.sv
// Types shared by the request router modules.
// Assumes the constants header sits beside it.
`include "drr_cfg.svh"

package drr_pkg;

    // Channel configuration byte
    typedef struct packed {
        logic enable;
        logic gate;
        logic [`DRR_SRC_W-1:0] source;
    } drr_cfg_t;

    // Gate state of one periodic channel
    typedef enum logic [1:0] {
        DRR_IDLE,
        DRR_WAIT_TICK,
        DRR_OPEN
    } drr_gate_st_t;

endpackage

// file: design/drr_gate.sv
// Periodic gate for one routing channel.
// Assumes request and tick are synchronous one-clock signals.
`timescale 1ns/1ps

module drr_gate
    import drr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Gate control
    input wire logic gate_on_in,
    input wire logic req_in,
    input wire logic tick_in,
    // Gated request
    output logic req_out
);

    typedef struct packed {
        drr_gate_st_t st;
    } drr_gate_state_t;

    drr_gate_state_t s_q;
    drr_gate_state_t s_d;

    // ----------------------------------------
    // Gate sequencing
    // ----------------------------------------
    // Next state of the gate
    always_comb begin
        s_d = s_q;
        if (!gate_on_in || !req_in) begin
            s_d.st = DRR_IDLE;
        end else begin
            unique case (s_q.st)
                DRR_IDLE: begin
                    // Request rising while a tick lands opens at once
                    s_d.st = tick_in ? DRR_OPEN : DRR_WAIT_TICK;
                end
                DRR_WAIT_TICK: begin
                    if (tick_in) begin
                        s_d.st = DRR_OPEN;
                    end
                end
                DRR_OPEN: begin
                    s_d.st = DRR_OPEN;
                end
                default: begin
                    s_d.st = DRR_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s_q <= '{st: DRR_IDLE};
        end else begin
            s_q <= s_d;
        end
    end

    // Gated request: tick with no request leaves it closed
    assign req_out = req_in && (!gate_on_in || s_q.st == DRR_OPEN);

    a_gate_blocks: assert property (@(posedge clk_in) disable iff (reset_in)
        gate_on_in && $rose(req_in) && !$past(tick_in) |-> !req_out)
        else $error("Gated request passed before a tick");

    // A tick seen beside a standing request opens the gate at the next edge
    a_tick_opens: assert property (@(posedge clk_in) disable iff (reset_in)
        (gate_on_in && req_in && tick_in) ##1 (gate_on_in && req_in) |-> req_out)
        else $error("Tick with a standing request did not open the gate");

endmodule

// file: design/drr_router.sv
// Request router: sixteen configuration bytes steer peripheral and
// always-on sources onto sixteen transfer-engine request lines.
// Assumes synchronous requests and one-cycle timer ticks on CLK_IN.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "drr_cfg.svh"

module drr_router
    import drr_pkg::*;
#(
    parameter int NUM_CH = `DRR_NUM_CH,
    parameter int NUM_GATED = `DRR_NUM_GATED,
    parameter int NUM_PERIPH = `DRR_NUM_PERIPH
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // Register port
    input wire logic [`DRR_ADDR_W-1:0] ADDR_IN,
    input wire logic [`DRR_DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [`DRR_DATA_W-1:0] RDATA_OUT,
    // Peripheral requests, index = source code, bit 0 unused
    input wire logic [NUM_PERIPH-1:0] PERIPH_REQ_IN,
    // Interval timer ticks, bit n from timer n+1
    input wire logic [NUM_GATED-1:0] TICK_IN,
    // Transfer engine requests
    output logic [NUM_CH-1:0] ENGINE_REQ_OUT
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        drr_cfg_t [NUM_CH-1:0] cfg;
        logic [`DRR_DATA_W-1:0] rdata;
        logic [NUM_CH-1:0] req;
    } drr_state_t;

    drr_state_t s_q;
    drr_state_t s_d;
    logic [NUM_CH-1:0] sel_req;
    logic [NUM_CH-1:0] routed;

    // Request level of one source code; zero and unused codes give none
    function automatic logic src_level(input logic [`DRR_SRC_W-1:0] code,
                                       input logic [NUM_PERIPH-1:0] periph);
        logic lvl;
        lvl = 1'b0;
        if (code >= `DRR_SRC_ALWAYS_LO && code <= `DRR_SRC_ALWAYS_HI) begin
            lvl = 1'b1;
        end else if (code != `DRR_SRC_NONE && code <= `DRR_SRC_PERIPH_HI) begin
            lvl = periph[code];
        end
        return lvl;
    endfunction

    // ----------------------------------------
    // Per-channel selection and gating
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            // Disabled channel blocks its source without touching the peripheral
            assign sel_req[g] = s_q.cfg[g].enable
                && src_level(s_q.cfg[g].source, PERIPH_REQ_IN);
            if (g < NUM_GATED) begin : g_gated
                // Channel g gated by timer g+1, which is tick bit g
                drr_gate u_gate (
                    .clk_in(CLK_IN),
                    .reset_in(RESET_IN),
                    .gate_on_in(s_q.cfg[g].gate),
                    .req_in(sel_req[g]),
                    .tick_in(TICK_IN[g]),
                    .req_out(routed[g])
                );
            end else begin : g_direct
                assign routed[g] = sel_req[g];
            end
        end
    endgenerate

    // ----------------------------------------
    // Register port and output registers
    // ----------------------------------------
    // Next state: configuration writes, read data, request outputs
    always_comb begin
        s_d = s_q;
        if (WR_IN) begin
            s_d.cfg[ADDR_IN] = drr_cfg_t'(WDATA_IN);
        end
        s_d.rdata = RD_IN ? s_q.cfg[ADDR_IN] : 8'h00;
        s_d.req = routed;
    end

    // State register; reset clears all sources and enables
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_OUT = s_q.rdata;
    assign ENGINE_REQ_OUT = s_q.req;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_disabled_quiet: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        !s_q.cfg[0].enable ##1 1'b1 |-> !ENGINE_REQ_OUT[0])
        else $error("Disabled channel 0 requested");

    a_always_on: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.cfg[8].enable && s_q.cfg[8].source == `DRR_SRC_ALWAYS_LO
        |=> ENGINE_REQ_OUT[8])
        else $error("Always-on source not routed");

    a_direct_hi: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.cfg[9].enable && s_q.cfg[9].source != `DRR_SRC_NONE
        && s_q.cfg[9].source <= `DRR_SRC_PERIPH_HI
        |=> ENGINE_REQ_OUT[9] == $past(PERIPH_REQ_IN[s_q.cfg[9].source]))
        else $error("Channel 9 not routed directly");

    a_write_read: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        WR_IN ##1 RD_IN && ADDR_IN == $past(ADDR_IN) && !$past(RD_IN)
        |=> RDATA_OUT == $past(WDATA_IN, 2))
        else $error("Configuration read-back mismatch");

    // Leaving reset shows all configurations and outputs cleared
    a_reset_clears: assert property (@(posedge CLK_IN)
        $fell(RESET_IN) |-> ENGINE_REQ_OUT == '0 && RDATA_OUT == '0 && s_q.cfg == '0)
        else $error("Reset left a configuration or output set");

    // A code above the always-on range never requests
    a_unused_code: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.cfg[0].source > `DRR_SRC_ALWAYS_HI |=> !ENGINE_REQ_OUT[0])
        else $error("Unused source code requested on channel 0");

    // Gate-capable channel with gate clear routes its peripheral directly
    a_direct_lo: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
        s_q.cfg[3].enable && !s_q.cfg[3].gate && s_q.cfg[3].source != `DRR_SRC_NONE
        && s_q.cfg[3].source <= `DRR_SRC_PERIPH_HI
        |=> ENGINE_REQ_OUT[3] == $past(PERIPH_REQ_IN[s_q.cfg[3].source]))
        else $error("Channel 3 not routed transparently");

    // Ungated channels pass the selected level straight through
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_chk
            a_ungated_pass: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
                (c >= NUM_GATED || !s_q.cfg[c].gate)
                |=> ENGINE_REQ_OUT[c] == $past(sel_req[c]))
                else $error("Ungated channel did not follow its source");
        end
    endgenerate

endmodule

// file: verif/drr_far_model.sv
// Far-side model: peripheral request levels and interval timer ticks.
// Assumes the bench sets levels and tick pulses just after the rising edge.
`timescale 1ns/1ps

module drr_far_model (
    // Clock
    input wire logic clk_in,
    // Bench commands
    input wire logic [34:0] want_in,
    input wire logic [7:0] pulse_in,
    // Router inputs
    output logic [34:0] req_out,
    output logic [7:0] tick_out
);
    // ----------------------------------------
    // Request and tick registers
    // ----------------------------------------
    // Code zero never requests; a tick lasts as long as its pulse command, one cycle later
    always_ff @(posedge clk_in) begin
        req_out <= want_in & 35'h7FFFFFFFE;
        tick_out <= pulse_in;
    end
endmodule

// file: verif/test_dma_request_router.sv
// Self-checking bench for the request router.
// Assumes the far-side model feeds requests and ticks one cycle after the bench.
`timescale 1ns/1ps

module test_dma_request_router;
    import drr_pkg::*;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [34:0] want = 35'h000000000;
    logic [7:0] pulse = 8'h00;
    logic [7:0] rdata;
    logic [15:0] engine;
    logic [34:0] req;
    logic [7:0] tick;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    // Clock of 8 ns
    initial forever #4 clk = ~clk;

    drr_far_model FAR (.clk_in(clk), .want_in(want), .pulse_in(pulse),
        .req_out(req), .tick_out(tick));
    drr_router DUT (.CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PERIPH_REQ_IN(req),
        .TICK_IN(tick), .ENGINE_REQ_OUT(engine));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_cfg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_cfg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("config", {8'h00, exp}, {8'h00, rdata});
    endtask

    // Write then read the same index with no gap between the strobes
    task automatic wr_rd_cfg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("config", {8'h00, d}, {8'h00, rdata});
    endtask

    task automatic pass_cyc(input int n, input logic [15:0] exp);
        repeat (n) @(posedge clk);
        #1 chk("engine", exp, engine);
    endtask

    task automatic set_want(input logic [34:0] v);
        @(posedge clk);
        want <= v;
    endtask

    task automatic tick_once(input logic [7:0] p);
        @(posedge clk);
        pulse <= p;
        @(posedge clk);
        pulse <= 8'h00;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 16; i++) rd_cfg(i[3:0], 8'h00);
        pass_cyc(1, 16'h0000);
    endtask

    task automatic t_direct;
        wr_rd_cfg(4'h0, 8'h89);
        set_want(35'h000000200);
        pass_cyc(4, 16'h0001);
        wr_cfg(4'h0, 8'h09);
        pass_cyc(3, 16'h0000);
        wr_cfg(4'h0, 8'hAB);
        set_want(35'h7FFFFFFFF);
        pass_cyc(4, 16'h0000);
        wr_cfg(4'h0, 8'h00);
        wr_cfg(4'h3, 8'h85);
        wr_cfg(4'h9, 8'hCD);
        set_want(35'h000002020);
        pass_cyc(4, 16'h0208);
        wr_cfg(4'h9, 8'h8D);
        rd_cfg(4'h9, 8'h8D);
        pass_cyc(2, 16'h0208);
        wr_cfg(4'h3, 8'h00);
        wr_cfg(4'h9, 8'h00);
        set_want(35'h000000000);
    endtask

    task automatic t_always;
        for (int i = 0; i < 8; i++) wr_cfg(4'h8 + i[3:0], 8'hA3 + i[7:0]);
        pass_cyc(3, 16'hFF00);
        for (int i = 0; i < 8; i++) wr_cfg(4'h8 + i[3:0], 8'h00);
        wr_cfg(4'h0, 8'hE3);
        pass_cyc(6, 16'h0000);
        tick_once(8'h01);
        pass_cyc(4, 16'h0001);
        pass_cyc(4, 16'h0001);
        wr_cfg(4'h0, 8'h00);
    endtask

    task automatic t_gated;
        wr_cfg(4'h3, 8'h00);
        wr_cfg(4'h3, 8'hC5);
        tick_once(8'h08);
        set_want(35'h000000020);
        pass_cyc(6, 16'h0000);
        tick_once(8'h10);
        pass_cyc(4, 16'h0000);
        tick_once(8'h08);
        pass_cyc(4, 16'h0008);
        set_want(35'h000000000);
        pass_cyc(4, 16'h0000);
        set_want(35'h000000020);
        pass_cyc(6, 16'h0000);
    endtask

    // Reset in mid-run clears a live configuration and its request
    task automatic t_midreset;
        wr_cfg(4'h5, 8'hA3);
        pass_cyc(2, 16'h0020);
        @(posedge clk);
        rst <= 1'b1;
        pass_cyc(2, 16'h0000);
        @(posedge clk);
        rst <= 1'b0;
        rd_cfg(4'h5, 8'h00);
        pass_cyc(2, 16'h0000);
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_direct();
        t_always();
        t_gated();
        t_midreset();
        tally_and_finish();
    end

    // Whole run takes well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            tally_and_finish();
        end
    end
endmodule
